//--- hdl/option_bit_reset_loader.sv
/*
  Reset-time loader for flash option bytes.
  Assumes rst_i covers system reset, power-on reset and stop-mode recovery,
  and flash answers a read one clock after the address is presented.
*/
`timescale 1ns/10ps
module option_bit_reset_loader (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  output logic [option_loader_pkg::ADDR_W-1:0]   flash_addr_o,
  output logic                                   flash_rd_o,
  input  wire logic [7:0]                        flash_data_i,
  input  wire logic                              wdt_timeout_i,
  output logic                                   core_reset_o,
  output logic                                   load_done_o,
  output option_loader_pkg::option_cfg_t         cfg_o,
  output option_loader_pkg::trim_cal_t           trim_o,
  output logic                                   wdt_run_o,
  output logic                                   wdt_irq_o,
  output logic                                   wdt_sys_reset_o
);
  import option_loader_pkg::*;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // A programmed (0) flash bit turns a protection on; erased parts
  // come up unprotected
  function automatic logic prot_on(input logic flash_bit);
    return ~flash_bit;
  endfunction : prot_on

  // ------------------------------------------------------------
  // Fetch sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_ADDR, ST_DATA, ST_DONE} state_t;

  state_t            state_reg, state_next;
  logic [CNT_W-1:0]  idx_reg, idx_next;
  logic [7:0]        opt_mem [OPT_BYTES];
  option_cfg_t       cfg_reg;
  trim_cal_t         trim_reg;
  logic              core_reset_reg, done_reg;
  logic              rd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              irq_reg, sysrst_reg, run_reg;

  wire last_byte = (idx_reg == LAST_IDX);
  wire capture   = (state_reg == ST_DATA);
  wire loading   = (state_reg != ST_DONE);

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    unique case (state_reg)
      ST_ADDR: state_next = ST_DATA;
      ST_DATA: begin
        if (last_byte) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_ADDR;
          idx_next   = idx_reg + 3'h1;
        end
      end
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_ADDR; // Illegal code returns to ST_ADDR and re-reads the current byte
    endcase
  end

  // Any reset restarts the fetch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_ADDR;
      idx_reg   <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
    end
  end

  wire [ADDR_W-1:0] addr_next = OPT_BASE + ADDR_W'(idx_next);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_reg   <= 1'b1;
      addr_reg <= OPT_BASE;
    end else begin
      rd_reg   <= (state_next == ST_ADDR);
      addr_reg <= addr_next;
    end
  end

  // ------------------------------------------------------------
  // Hidden holding bytes
  // ------------------------------------------------------------
  // No core bus reaches this array; only this sequencer writes it
  always_ff @(posedge clk_i) begin
    if (capture) begin
      opt_mem[idx_reg] <= flash_data_i;
    end
  end

  wire [7:0] b0 = opt_mem[0];
  wire [7:0] b1 = opt_mem[1];
  wire option_cfg_t cfg_from_mem = '{
    watchdog_response_select:         b0[WDT_RSP_BIT],
    wdt_always_on:                    b0[WDT_ON_BIT],
    supply_brownout_detector_stop_on: b0[BOD_STOP_BIT],
    osc_mode:         osc_mode_t'(b0[OSC_LSB+1:OSC_LSB]),
    code_read_block:       prot_on(b0[RD_PROT_BIT]),
    code_write_block_all:  prot_on(b0[WR_PROT_BIT]),
    code_write_block_part: prot_on(b1[PART_PROT_BIT])
  };
  wire trim_cal_t trim_from_mem = '{
    osc_trim: opt_mem[OSC_TRIM_IDX],
    lvd_trim: opt_mem[LVD_TRIM_IDX],
    adc_cal:  opt_mem[ADC_CAL_IDX],
    temp_cal: opt_mem[TEMP_CAL_IDX],
    wdt_cal:  opt_mem[WDT_CAL_IDX]
  };

  // Last byte lands this cycle, so apply from the next one
  wire apply = (state_reg == ST_DONE) && !done_reg;

  // cfg_o and trim_o frozen after apply; later flash edits wait for a reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg        <= CFG_RESET;
      trim_reg       <= TRIM_RESET;
      done_reg       <= 1'b0;
      core_reset_reg <= 1'b1;
    end else if (apply) begin
      cfg_reg        <= cfg_from_mem;
      trim_reg       <= trim_from_mem;
      done_reg       <= 1'b1;
      core_reset_reg <= 1'b1;
    end else if (done_reg) begin
      core_reset_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Watchdog steering
  // ------------------------------------------------------------
  wire to_seen = wdt_timeout_i && done_reg && !core_reset_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg    <= 1'b0;
      sysrst_reg <= 1'b0;
      run_reg    <= 1'b0;
    end else begin
      irq_reg    <= to_seen && !cfg_reg.watchdog_response_select;
      sysrst_reg <= to_seen && cfg_reg.watchdog_response_select;
      run_reg    <= done_reg && cfg_reg.wdt_always_on;
    end
  end

  assign flash_addr_o    = addr_reg;
  assign flash_rd_o      = rd_reg;
  assign core_reset_o    = core_reset_reg;
  assign load_done_o     = done_reg;
  assign cfg_o           = cfg_reg;
  assign trim_o          = trim_reg;
  assign wdt_run_o       = run_reg;
  assign wdt_irq_o       = irq_reg;
  assign wdt_sys_reset_o = sysrst_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  reset_during_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i) loading |-> core_reset_o)
    else $error("core left reset while loading");

  release_after_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(core_reset_o) |-> load_done_o)
    else $error("core released before options applied");

  load_finishes_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(load_done_o) |-> ##1 !core_reset_o)
    else $error("core reset not released after load");

  cfg_stable_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(load_done_o) |-> $stable(cfg_o) && $stable(trim_o))
    else $error("configuration changed after load");

  wdt_reset_sel_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wdt_sys_reset_o |-> cfg_o.watchdog_response_select && !wdt_irq_o)
    else $error("watchdog reset without reset selection");

  wdt_irq_sel_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (to_seen && !cfg_o.watchdog_response_select) |=> wdt_irq_o)
    else $error("watchdog interrupt missing");

  wdt_always_on_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (load_done_o && cfg_o.wdt_always_on) |=> wdt_run_o)
    else $error("watchdog not forced on");

  fetch_no_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i) load_done_o |-> !flash_rd_o)
    else $error("flash read after load");

  rd_alternates_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (loading && flash_rd_o) |=> !flash_rd_o)
    else $error("read strobe held for two cycles");

  rd_next_byte_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (capture && !last_byte) |=> flash_rd_o)
    else $error("next option byte not requested");

  addr_tracks_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (loading && flash_rd_o) |-> flash_addr_o == OPT_BASE + ADDR_W'(idx_reg))
    else $error("flash address out of step with byte index");

  addr_in_area_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flash_rd_o |-> flash_addr_o < OPT_BASE + ADDR_W'(OPT_BYTES))
    else $error("read outside the option area");

  capture_after_rd_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    capture |-> $past(flash_rd_o))
    else $error("byte captured without a read");

  no_capture_done_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    load_done_o |-> !capture)
    else $error("holding bytes rewritten after load");

  done_holds_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    load_done_o |=> load_done_o)
    else $error("load done dropped without reset");

  core_stays_run_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (load_done_o && !core_reset_o) |=> !core_reset_o)
    else $error("core reset reasserted without reset");

  cfg_erased_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !load_done_o |-> cfg_o == CFG_RESET)
    else $error("options not at erased default while loading");

  trim_erased_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !load_done_o |-> trim_o == TRIM_RESET)
    else $error("trim not at erased default while loading");

  no_wdt_held_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    core_reset_o |=> !wdt_irq_o && !wdt_sys_reset_o)
    else $error("watchdog action while core held");

  wdt_one_action_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wdt_irq_o && wdt_sys_reset_o))
    else $error("watchdog raised both interrupt and reset");

  irq_has_cause_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wdt_irq_o |-> $past(wdt_timeout_i))
    else $error("watchdog interrupt without time-out");

  wdt_sysrst_sel_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (to_seen && cfg_o.watchdog_response_select) |=> wdt_sys_reset_o)
    else $error("watchdog system reset missing");

  run_off_loading_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !load_done_o |-> !wdt_run_o)
    else $error("watchdog forced on before options applied");

  run_follows_opt_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (load_done_o && !cfg_o.wdt_always_on) |=> !wdt_run_o)
    else $error("watchdog forced on against option");

  // ------------------------------------------------------------
  // Load timing monitor
  // ------------------------------------------------------------
  // Edges from reset release to load done: two per byte plus apply
  localparam int LOAD_EDGES = 2 * OPT_BYTES + 1;

  logic [4:0] fetch_cnt_reg;

  // Helper only; stops counting once the load is done
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_cnt_reg <= '0;
    end else if (!done_reg) begin
      fetch_cnt_reg <= fetch_cnt_reg + 5'h01;
    end
  end

  fetch_length_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(load_done_o) |-> fetch_cnt_reg == 5'(LOAD_EDGES))
    else $error("option load took the wrong number of cycles");

endmodule : option_bit_reset_loader

//--- hdl/option_loader_pkg.sv
/*
  Constants and carrier types for the reset-time option loader.
  Assumes a flash read port that answers a byte read with fixed latency.
*/
// Behaviour
// - Every reset kind starts a fresh fetch of all option bytes from flash.
// - Flash changes after loading have no effect until the next reset.
// - Loading finishes and controls apply before the core leaves reset.
// - The holding registers have no read or write path from the core.
// - One loaded bit picks interrupt or system reset on watchdog time-out.
// - One loaded bit keeps the watchdog running from reset without software.
// - One loaded bit blocks external read access to user code.
// - Loaded bits inhibit program and erase of all or part of user code.
// - One loaded bit keeps or drops the brownout detector in stop state.
// - Loaded bits pick high, medium, low power crystal or external RC mode.
// - Trim and calibration bytes are delivered for oscillator, detector,
//       converter, temperature sensor and watchdog compensation.
// - Response bit 1 (erased default) means reset, 0 means interrupt.
package option_loader_pkg;

  localparam int          ADDR_W       = 13;
  localparam int          OPT_BYTES    = 8;
  localparam int          CNT_W        = 3;
  localparam logic [ADDR_W-1:0] OPT_BASE = 13'h0000;
  localparam int          FLASH_LAT    = 1;
  localparam logic [CNT_W-1:0] LAST_IDX = 3'h7;

  // Byte 0 bit positions
  localparam int          WDT_RSP_BIT  = 7;
  localparam int          WDT_ON_BIT   = 6;
  localparam int          BOD_STOP_BIT = 5;
  localparam int          OSC_LSB      = 3;
  localparam int          RD_PROT_BIT  = 1;
  localparam int          WR_PROT_BIT  = 0;
  // Byte 1 bit position
  localparam int          PART_PROT_BIT = 0;
  // Trim and calibration byte indices
  localparam int          OSC_TRIM_IDX  = 2;
  localparam int          LVD_TRIM_IDX  = 3;
  localparam int          ADC_CAL_IDX   = 4;
  localparam int          TEMP_CAL_IDX  = 5;
  localparam int          WDT_CAL_IDX   = 6;

  typedef enum logic [1:0] {
    OSC_HIGH_XTAL = 2'h3,
    OSC_MED_XTAL  = 2'h2,
    OSC_LOW_XTAL  = 2'h1,
    OSC_EXT_RC    = 2'h0
  } osc_mode_t;

  typedef struct packed {
    logic       watchdog_response_select;
    logic       wdt_always_on;
    logic       supply_brownout_detector_stop_on;
    osc_mode_t  osc_mode;
    logic       code_read_block;
    logic       code_write_block_all;
    logic       code_write_block_part;
  } option_cfg_t;

  typedef struct packed {
    logic [7:0] osc_trim;
    logic [7:0] lvd_trim;
    logic [7:0] adc_cal;
    logic [7:0] temp_cal;
    logic [7:0] wdt_cal;
  } trim_cal_t;

  // Erased flash reads all ones
  localparam option_cfg_t CFG_RESET  = 8'hFF;
  localparam trim_cal_t   TRIM_RESET = 40'hFF_FFFF_FFFF;

endpackage : option_loader_pkg

//--- test/flash_option_model.sv
/*
  Behavioural option area of program flash, eight bytes.
  Assumes a read strobe with address, answered on the next clock.
*/
`timescale 1ns/10ps
module flash_option_model (
  input  wire logic                            clk_i,
  input  wire logic [option_loader_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                            rd_i,
  output logic [7:0]                           data_o
);
  import option_loader_pkg::*;
  // Bench rewrites this at will, also after loading
  logic [7:0] mem [8];

  // Idle cycles toggle the bus so a late sample never sees old data
  always_ff @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= mem[addr_i[CNT_W-1:0]];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : flash_option_model

//--- test/tb.sv
/*
  Self-checking bench for the option loader with a flash model.
  Assumes the loader's 16-cycle fetch and registered watchdog pulses.
*/
`timescale 1ns/10ps
module tb;
  import option_loader_pkg::*;
  logic              clk_i, rst_i, wdt_timeout_i;
  logic [ADDR_W-1:0] flash_addr_o;
  logic              flash_rd_o, core_reset_o, load_done_o;
  logic [7:0]        flash_data_i;
  logic              wdt_run_o, wdt_irq_o, wdt_sys_reset_o;
  option_cfg_t       cfg_o;
  trim_cal_t         trim_o;
  logic [7:0]        img [8];
  logic [47:0]       exp_ld_q [$];
  logic [1:0]        exp_wd_q [$];
  logic [47:0]       last_exp;
  logic [47:0]       exp_now;
  logic              prev_core, prev_done;
  int                miscompares, total_checks;

  option_bit_reset_loader u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o),
    .flash_data_i(flash_data_i), .wdt_timeout_i(wdt_timeout_i),
    .core_reset_o(core_reset_o), .load_done_o(load_done_o), .cfg_o(cfg_o),
    .trim_o(trim_o), .wdt_run_o(wdt_run_o), .wdt_irq_o(wdt_irq_o),
    .wdt_sys_reset_o(wdt_sys_reset_o));
  flash_option_model u_flash (.clk_i(clk_i), .addr_i(flash_addr_o),
    .rd_i(flash_rd_o), .data_o(flash_data_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (!rst_i && prev_core && core_reset_o === 1'b0) begin
      exp_now = exp_ld_q.size() > 0 ? exp_ld_q.pop_front() : 48'hX;
      check("done before core run", {47'h0, prev_done}, 48'h1);
      check("loaded options", {cfg_o, trim_o}, exp_now);
      check("forced run", 48'(wdt_run_o), 48'(exp_now[46]));
    end
    if (wdt_irq_o === 1'b1 || wdt_sys_reset_o === 1'b1) begin
      check("watchdog action", {46'h0, wdt_irq_o, wdt_sys_reset_o},
            exp_wd_q.size() > 0 ? exp_wd_q.pop_front() : 48'hX);
    end
    prev_core = core_reset_o;
    prev_done = load_done_o;
  end

  // Sanity bound: the whole run is a few hundred cycles
  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    wdt_timeout_i = 1'b0;
    miscompares = 0;
    total_checks = 0;
    prev_core = 1'b1;
    prev_done = 1'b0;
    void'($urandom(26500));
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 8; j++) img[j] = 8'($urandom);
      img[0][4:3] = 2'(k);
      img[0][7] = k[0];
      for (int j = 0; j < 8; j++) u_flash.mem[j] = img[j];
      if (k > 0) begin
        repeat (20) @(posedge clk_i);
        check("options held", {cfg_o, trim_o}, last_exp);
      end
      // Protections are on where the flash bit is programmed to 0
      last_exp = {img[0][7:5], img[0][4:3], ~img[0][1], ~img[0][0],
                  ~img[1][0], img[2], img[3], img[4], img[5], img[6]};
      exp_ld_q.push_back(last_exp);
      @(posedge clk_i) #1 rst_i = 1'b1;
      repeat (k == 0 ? 10 : 2) @(posedge clk_i);
      #1 rst_i = 1'b0;
      wdt_timeout_i = 1'b1; // Refused while the core is held
      repeat (10) @(posedge clk_i);
      #1 wdt_timeout_i = 1'b0;
      repeat (15) @(posedge clk_i);
      exp_wd_q.push_back(img[0][7] ? 2'b01 : 2'b10);
      #1 wdt_timeout_i = 1'b1;
      @(posedge clk_i) #1 wdt_timeout_i = 1'b0;
      repeat (4) @(posedge clk_i);
      $display("test %0d finished", k);
    end
    check("pending notes", 48'(exp_ld_q.size() + exp_wd_q.size()), 48'h0);
    close_out();
  end
endmodule : tb
